// ===== ppmc_params.svh
// ppmc_params.svh: offsets, field positions, reset values and timing counts
// for the parallel port mode and configuration block.
// assumes inclusion by bare name from the block's design files.
`ifndef PPMC_PARAMS_SVH
`define PPMC_PARAMS_SVH

// ----------------------------------------------------------------------------
// port register offsets from the port base
// ----------------------------------------------------------------------------
`define PPMC_OFS_DATA        11'h000
`define PPMC_OFS_STATUS      11'h001
`define PPMC_OFS_CONTROL     11'h002
`define PPMC_OFS_FIFO        11'h400
`define PPMC_OFS_EXT_CTRL    11'h402
`define PPMC_OFS_MODE_INDEX  11'h403
`define PPMC_OFS_MODE_DATA   11'h404

// ----------------------------------------------------------------------------
// configuration space indexes
// ----------------------------------------------------------------------------
`define PPMC_CFG_SETUP       8'hf0
`define PPMC_CFG_FUNC_EN     8'hf8
`define PPMC_CFG_IRQ_SEL     8'h70
`define PPMC_CFG_DMA_SEL     8'h74

// ----------------------------------------------------------------------------
// second level index and field positions
// ----------------------------------------------------------------------------
`define PPMC_IDX_SECOND_CTRL 3'h2
`define PPMC_SLC_COMPAT_BIT  7
`define PPMC_SLC_EPP19_BIT   4
`define PPMC_SETUP_DYN_BIT   4
`define PPMC_FER_PORT_EN_BIT 4
`define PPMC_CTR_STROBE_BIT  0
`define PPMC_CTR_AFEED_BIT   1
`define PPMC_CTR_INIT_BIT    2
`define PPMC_CTR_SELIN_BIT   3
`define PPMC_CTR_IRQEN_BIT   4
`define PPMC_CTR_DIR_BIT     5
`define PPMC_ECR_DMAEN_BIT   3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PPMC_RST_SETUP       8'he0
`define PPMC_RST_EXT_CTRL    8'h60
`define PPMC_RST_CONTROL     8'h04
`define PPMC_RST_SECOND_CTRL 8'h00
`define PPMC_RST_FUNC_EN     8'h00
`define PPMC_RST_IRQ_SEL     4'h7
`define PPMC_RST_DMA_SEL     2'h3

// ----------------------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------------------
`define PPMC_FIFO_DEPTH      32
`define PPMC_ECP_LEVELS      16
`define PPMC_CLK_PERIOD_NS   10
`define PPMC_STROBE_NS       50

`endif

// ===== ppmc_pkg.sv
// ppmc_pkg.sv: types shared by the parallel port mode block.
// assumes nothing beyond a SystemVerilog compiler.
package ppmc_pkg;

  typedef enum logic [2:0] {
    PPMC_SPP_COMPAT = 3'b000,
    PPMC_SPP_EXT    = 3'b001,
    PPMC_OUT_FIFO   = 3'b010,
    PPMC_ECP        = 3'b011,
    PPMC_EPP17      = 3'b100,
    PPMC_EPP19      = 3'b101
  } ppmc_mode_t;

  typedef enum logic [1:0] {
    PPMC_DR_IDLE   = 2'b00,
    PPMC_DR_SETUP  = 2'b01,
    PPMC_DR_STROBE = 2'b10,
    PPMC_DR_HOLD   = 2'b11
  } ppmc_drain_t;

endpackage

// ===== ppmc_fifo.sv
// ppmc_fifo.sv: synchronous FIFO with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ppmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rptr_r];
  assign level     = count_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ===== ppmc_core.sv
// ppmc_core.sv: parallel port mode selection, run-time reconfiguration,
// routing of interrupt and DMA, activation and handshake pin control.
// assumes a system I/O port with one-cycle read/write strobes and
// a configuration space port, both synchronous to core_clk.
`timescale 1ns/1ps
`include "ppmc_params.svh"
module ppmc_core (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic [10:0]        io_addr,
  input  wire logic               io_wr,
  input  wire logic               io_rd,
  input  wire logic [7:0]         io_wdata,
  output logic [7:0]              io_rdata,
  output logic                    io_wr_ready,
  input  wire logic [7:0]         cfg_index,
  input  wire logic               cfg_wr,
  input  wire logic               cfg_rd,
  input  wire logic [7:0]         cfg_wdata,
  output logic [7:0]              cfg_rdata,
  output ppmc_pkg::ppmc_mode_t    mode,
  output logic                    compat_variant,
  output logic                    full_handshake,
  output logic [7:0]              pd_o,
  output logic                    pd_oe,
  input  wire logic [7:0]         pd_i,
  output logic                    data_strobe_out_n,
  output logic                    data_strobe_oe,
  output logic                    auto_feed_out_n,
  output logic                    auto_feed_oe,
  output logic                    select_in_out_n,
  output logic                    select_in_oe,
  output logic                    init_out_n,
  output logic                    init_oe,
  input  wire logic               busy_i,
  input  wire logic               ack_n_i,
  input  wire logic               paper_end_i,
  input  wire logic               select_i,
  input  wire logic               error_n_i,
  output logic [15:0]             irq_o,
  output logic [15:0]             irq_oe,
  output logic [2:0]              drq_o,
  input  wire logic [2:0]         dack_i
);
  import ppmc_pkg::*;

  localparam int STROBE_CYC_I = (`PPMC_STROBE_NS + `PPMC_CLK_PERIOD_NS - 1) / `PPMC_CLK_PERIOD_NS;
  localparam logic [7:0] STROBE_CYC = (STROBE_CYC_I < 1) ? 8'h01 : STROBE_CYC_I[7:0];

  // --------------------------------------------------------------------------
  // configuration space registers
  // --------------------------------------------------------------------------
  logic [7:0] setup_r;
  logic [7:0] func_en_r;
  logic [3:0] irq_sel_r;
  logic [1:0] dma_sel_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      setup_r   <= `PPMC_RST_SETUP;
      func_en_r <= `PPMC_RST_FUNC_EN;
      irq_sel_r <= `PPMC_RST_IRQ_SEL;
      dma_sel_r <= `PPMC_RST_DMA_SEL;
    end else if (cfg_wr) begin
      case (cfg_index)
        `PPMC_CFG_SETUP:   setup_r   <= cfg_wdata;
        `PPMC_CFG_FUNC_EN: func_en_r <= cfg_wdata;
        `PPMC_CFG_IRQ_SEL: irq_sel_r <= cfg_wdata[3:0];
        `PPMC_CFG_DMA_SEL: dma_sel_r <= cfg_wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_index)
        `PPMC_CFG_SETUP:   cfg_rdata <= setup_r;
        `PPMC_CFG_FUNC_EN: cfg_rdata <= func_en_r;
        `PPMC_CFG_IRQ_SEL: cfg_rdata <= {4'h0, irq_sel_r};
        `PPMC_CFG_DMA_SEL: cfg_rdata <= {6'h00, dma_sel_r};
        default:           cfg_rdata <= 8'h00;
      endcase
    end
  end

  logic active;
  assign active = func_en_r[`PPMC_FER_PORT_EN_BIT];

  // --------------------------------------------------------------------------
  // port registers
  // --------------------------------------------------------------------------
  logic [7:0] latch_r;
  logic [7:0] ctr_r;
  logic [7:0] ecr_r;
  logic [2:0] index_r;
  logic [7:0] slc_r;
  logic       irq_stat_n_r;
  logic       ack_d_r;
  logic       wr_hit;
  logic       rd_hit;

  assign wr_hit = io_wr && active;
  assign rd_hit = io_rd && active;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      latch_r <= 8'h00;
      ctr_r   <= `PPMC_RST_CONTROL;
      ecr_r   <= `PPMC_RST_EXT_CTRL;
      index_r <= 3'h0;
      slc_r   <= `PPMC_RST_SECOND_CTRL;
    end else if (wr_hit) begin
      case (io_addr)
        `PPMC_OFS_DATA:       latch_r <= io_wdata;
        `PPMC_OFS_CONTROL:    ctr_r   <= io_wdata;
        `PPMC_OFS_EXT_CTRL:   ecr_r   <= {io_wdata[7:2], 2'b00};
        `PPMC_OFS_MODE_INDEX: index_r <= io_wdata[2:0];
        `PPMC_OFS_MODE_DATA: begin
          if (index_r == `PPMC_IDX_SECOND_CTRL) begin
            slc_r <= io_wdata;
          end
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // effective mode decode
  // --------------------------------------------------------------------------
  logic dynamic;
  assign dynamic = setup_r[`PPMC_SETUP_DYN_BIT] &&
                   (setup_r[7:5] == 3'b110 || setup_r[7:5] == 3'b111 || setup_r[7:5] == 3'b100);

  always_comb begin
    mode = PPMC_ECP;
    if (!setup_r[7]) begin
      case (setup_r[6:5])
        2'b00:   mode = PPMC_SPP_COMPAT;
        2'b01:   mode = PPMC_SPP_EXT;
        2'b10:   mode = PPMC_EPP17;
        default: mode = PPMC_EPP19;
      endcase
    end else if (dynamic) begin
      case (ecr_r[7:5])
        3'b000:  mode = PPMC_SPP_COMPAT;
        3'b001:  mode = PPMC_SPP_EXT;
        3'b010:  mode = PPMC_OUT_FIFO;
        3'b100:  mode = slc_r[`PPMC_SLC_EPP19_BIT] ? PPMC_EPP19 : PPMC_EPP17;
        default: mode = PPMC_ECP;
      endcase
    end
  end

  assign compat_variant = dynamic && (mode != PPMC_ECP) && slc_r[`PPMC_SLC_COMPAT_BIT];
  assign full_handshake = (mode != PPMC_EPP17);

  // --------------------------------------------------------------------------
  // output FIFO and drain machine
  // --------------------------------------------------------------------------
  logic        fifo_mode;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;
  logic [5:0]  fifo_level;
  logic        ecp_room;
  logic        dma_ack;
  ppmc_drain_t drain_r;
  logic [7:0]  dcnt_r;
  logic [7:0]  drain_data_r;

  assign fifo_mode = active && (mode == PPMC_OUT_FIFO || mode == PPMC_ECP);
  // ECP exposes only 16 levels; the deeper buffer absorbs the drain pipeline
  assign ecp_room  = (mode != PPMC_ECP) || (fifo_level < 6'(`PPMC_ECP_LEVELS));
  assign dma_ack   = (dack_i != 3'b000) && (mode == PPMC_ECP) && ecr_r[`PPMC_ECR_DMAEN_BIT];
  assign fifo_in_valid = fifo_mode && ecp_room &&
                         ((io_wr && io_addr == `PPMC_OFS_FIFO) || dma_ack);
  assign io_wr_ready   = fifo_in_ready && ecp_room;
  assign fifo_out_ready = (drain_r == PPMC_DR_IDLE) && fifo_mode && !ctr_r[`PPMC_CTR_DIR_BIT] && !busy_i;

  ppmc_fifo #(
    .WIDTH (8),
    .DEPTH (`PPMC_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (io_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // busy from the printer stalls the drain, which backs the FIFO up
  always_ff @(posedge core_clk) begin
    if (srst) begin
      drain_r      <= PPMC_DR_IDLE;
      dcnt_r       <= 8'h00;
      drain_data_r <= 8'h00;
    end else begin
      case (drain_r)
        PPMC_DR_IDLE: begin
          if (fifo_out_valid && fifo_out_ready) begin
            drain_data_r <= fifo_out_data;
            drain_r      <= PPMC_DR_SETUP;
          end
        end
        PPMC_DR_SETUP: begin
          dcnt_r  <= STROBE_CYC;
          drain_r <= PPMC_DR_STROBE;
        end
        PPMC_DR_STROBE: begin
          dcnt_r <= dcnt_r - 8'h01;
          if (dcnt_r == 8'h01) begin
            drain_r <= PPMC_DR_HOLD;
          end
        end
        PPMC_DR_HOLD: begin
          if (!busy_i) begin
            drain_r <= PPMC_DR_IDLE;
          end
        end
        default: drain_r <= PPMC_DR_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // status, read path and interrupt status
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_d_r      <= 1'b1;
      irq_stat_n_r <= 1'b1;
    end else begin
      ack_d_r <= ack_n_i;
      // a new acknowledge edge beats a clearing status read
      if (mode == PPMC_SPP_EXT && ctr_r[`PPMC_CTR_IRQEN_BIT] && !ack_d_r && ack_n_i) begin
        irq_stat_n_r <= 1'b0;
      end else if (rd_hit && io_addr == `PPMC_OFS_STATUS) begin
        irq_stat_n_r <= 1'b1;
      end
    end
  end

  logic [7:0] status;
  assign status = {~busy_i, ack_n_i, paper_end_i, select_i, error_n_i,
                   (mode == PPMC_SPP_EXT) ? irq_stat_n_r : 1'b1, 1'b1, 1'b1};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_rdata <= 8'h00;
    end else if (rd_hit) begin
      case (io_addr)
        `PPMC_OFS_DATA:       io_rdata <= (mode != PPMC_SPP_COMPAT && ctr_r[`PPMC_CTR_DIR_BIT]) ?
                                          pd_i : latch_r;
        `PPMC_OFS_STATUS:     io_rdata <= status;
        `PPMC_OFS_CONTROL:    io_rdata <= ctr_r;
        `PPMC_OFS_EXT_CTRL:   io_rdata <= {ecr_r[7:2], !ecp_room || !fifo_in_ready, !fifo_out_valid};
        `PPMC_OFS_MODE_INDEX: io_rdata <= {5'h00, index_r};
        `PPMC_OFS_MODE_DATA:  io_rdata <= (index_r == `PPMC_IDX_SECOND_CTRL) ? slc_r : 8'h00;
        default:              io_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------------
  logic drain_strobe;
  assign drain_strobe = (drain_r == PPMC_DR_STROBE);
  assign pd_o  = (drain_r != PPMC_DR_IDLE) ? drain_data_r : latch_r;
  // compatible mode ignores the direction bit: drives whenever the port is active
  assign pd_oe = active && ((mode == PPMC_SPP_COMPAT) || !ctr_r[`PPMC_CTR_DIR_BIT]);

  assign data_strobe_out_n = !(ctr_r[`PPMC_CTR_STROBE_BIT] || drain_strobe);
  assign auto_feed_out_n   = !ctr_r[`PPMC_CTR_AFEED_BIT];
  assign select_in_out_n   = !ctr_r[`PPMC_CTR_SELIN_BIT];
  assign init_out_n        = !srst && active && ctr_r[`PPMC_CTR_INIT_BIT];
  assign init_oe           = 1'b1;
  assign data_strobe_oe    = active && !srst;
  assign auto_feed_oe      = active && !srst;
  assign select_in_oe      = active && !srst;

  logic port_irq;
  logic irq_legal;
  assign port_irq  = !irq_stat_n_r || (mode == PPMC_SPP_COMPAT && ctr_r[`PPMC_CTR_IRQEN_BIT] && !ack_n_i);
  assign irq_legal = irq_sel_r != 4'h0 && irq_sel_r != 4'h2 && irq_sel_r != 4'hd;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_irq
      assign irq_o[gi]  = port_irq;
      assign irq_oe[gi] = active && !srst && irq_legal && (irq_sel_r == 4'(gi));
    end
    for (gi = 0; gi < 3; gi++) begin : g_drq
      assign drq_o[gi] = active && (dma_sel_r == 2'(gi + 1)) && (mode == PPMC_ECP) &&
                         ecr_r[`PPMC_ECR_DMAEN_BIT] && ecp_room && fifo_in_ready;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  sequence s_strobe_low;
    !data_strobe_out_n [*5];
  endsequence

  property p_reset_ecp;
    @(posedge core_clk) $past(srst) && !srst |-> mode == PPMC_ECP && ctr_r[`PPMC_CTR_INIT_BIT];
  endproperty
  a_reset_ecp: assert property (p_reset_ecp) else $error("mode not ECP after reset");

  property p_static;
    @(posedge core_clk) disable iff (srst) cfg_wr && cfg_index == `PPMC_CFG_SETUP && cfg_wdata[7:5] == 3'b011
      |=> mode == PPMC_EPP19;
  endproperty
  a_static: assert property (p_static) else $error("static setup not applied");

  property p_dyn_epp;
    @(posedge core_clk) disable iff (srst) dynamic && ecr_r[7:5] == 3'b100
      |-> mode == (slc_r[4] ? PPMC_EPP19 : PPMC_EPP17);
  endproperty
  a_dyn_epp: assert property (p_dyn_epp) else $error("run-time EPP decode wrong");

  property p_no_dyn;
    @(posedge core_clk) disable iff (srst) setup_r[7:4] == 4'he |-> mode == PPMC_ECP;
  endproperty
  a_no_dyn: assert property (p_no_dyn) else $error("run-time change without enable");

  property p_index_read;
    @(posedge core_clk) disable iff (srst) rd_hit && io_addr == `PPMC_OFS_MODE_DATA && index_r == 3'h2
      |=> io_rdata == $past(slc_r);
  endproperty
  a_index_read: assert property (p_index_read) else $error("second level read wrong");

  property p_irq_route;
    @(posedge core_clk) disable iff (srst) irq_oe[2] == 1'b0 && irq_oe[13] == 1'b0 && irq_oe[0] == 1'b0;
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("illegal interrupt line driven");

  property p_inactive;
    @(posedge core_clk) !active |-> !pd_oe && !data_strobe_oe && irq_oe == 16'h0000 && drq_o == 3'b000;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive port drives pins");

  property p_reset_pins;
    @(posedge core_clk) srst |-> !init_out_n && init_oe && !select_in_oe && !auto_feed_oe && irq_oe == 16'h0000;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("reset pin states wrong");

  property p_drain_strobe;
    @(posedge core_clk) disable iff (srst) $rose(drain_strobe) |-> s_strobe_low ##1 (drain_r == PPMC_DR_HOLD);
  endproperty
  a_drain_strobe: assert property (p_drain_strobe) else $error("strobe width wrong");

  property p_ext_dir;
    @(posedge core_clk) disable iff (srst) mode == PPMC_SPP_EXT && ctr_r[5] |-> !pd_oe;
  endproperty
  a_ext_dir: assert property (p_ext_dir) else $error("extended mode drives while reading");
endmodule

// ===== ppmc_printer.sv
// ppmc_printer.sv: printer model that takes bytes off the strobe.
// assumes strobe and data come from the port on core_clk.
`timescale 1ns/1ps
module ppmc_printer (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       strobe_n,
  input  wire logic [7:0] pd,
  input  wire logic       stall,
  output logic            busy,
  output logic            ack_n,
  output logic [7:0]      got,
  output logic [7:0]      n_got,
  output logic [7:0]      slen
);
  logic [7:0] low_r;
  logic [2:0] cnt_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      low_r <= 8'h00;
      cnt_r <= 3'h0;
      n_got <= 8'h00;
    end else begin
      low_r <= strobe_n ? 8'h00 : low_r + 8'h01;
      cnt_r <= (strobe_n && low_r != 8'h00) ? 3'h4 : cnt_r - {2'h0, cnt_r != 3'h0};
      if (strobe_n && low_r != 8'h00) begin
        got <= pd;
        slen <= low_r;
        n_got <= n_got + 8'h01;
      end
    end
  end
  // busy covers the strobe and a short print time, so the drain waits in idle, not in hold, before the next byte
  assign busy = stall | ~strobe_n | (cnt_r > 3'h1);
  assign ack_n = (cnt_r != 3'h2);
endmodule

// ===== testbench.sv
// testbench.sv: self-checking bench for the port mode block.
// assumes ppmc_pkg, ppmc_fifo, ppmc_core and ppmc_printer compiled first.
`timescale 1ns/1ps
module testbench;
  import ppmc_pkg::*;
  logic        core_clk, srst, io_wr, io_rd, cfg_wr, cfg_rd, stall, io_wr_ready, pd_oe, busy_i, ack_n_i;
  logic        compat_variant, full_handshake, init_out_n, init_oe, data_strobe_out_n, data_strobe_oe;
  logic        auto_feed_out_n, auto_feed_oe, select_in_out_n, select_in_oe;
  logic [10:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, cfg_index, cfg_wdata, cfg_rdata, pd_o, pd_i, got, n_got, slen;
  logic [15:0] irq_o, irq_oe;
  logic [2:0]  drq_o, dack_i;
  ppmc_mode_t  mode;
  int          n_errors, samples_checked, cyc, k;
  // released data lines read back inverted so a stale level never matches
  assign pd_i = pd_oe ? pd_o : ~pd_o;
  ppmc_core i_dut (.core_clk, .srst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_wr_ready,
    .cfg_index, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .mode, .compat_variant, .full_handshake,
    .pd_o, .pd_oe, .pd_i, .data_strobe_out_n, .data_strobe_oe, .auto_feed_out_n, .auto_feed_oe,
    .select_in_out_n, .select_in_oe, .init_out_n, .init_oe, .busy_i, .ack_n_i, .paper_end_i(1'b0),
    .select_i(1'b1), .error_n_i(1'b1), .irq_o, .irq_oe, .drq_o, .dack_i);
  ppmc_printer i_prn (.core_clk, .srst, .strobe_n(data_strobe_oe ? data_strobe_out_n : 1'b1),
    .pd(pd_o), .stall, .busy(busy_i), .ack_n(ack_n_i), .got, .n_got, .slen);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] seen, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // c picks config space, w picks write; read data lands before return
  task automatic bus(input logic c, input logic w, input logic [10:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    cfg_index = a[7:0];
    io_wdata = d;
    cfg_wdata = d;
    {cfg_wr, cfg_rd, io_wr, io_rd} = {c & w, c & !w, !c & w, !c & !w};
    @(posedge core_clk);
    #1;
    {cfg_wr, cfg_rd, io_wr, io_rd} = 4'h0;
  endtask
  task test_done();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task t_reset();
    chk(8'h40, {init_out_n, init_oe, data_strobe_oe, auto_feed_oe, select_in_oe, pd_oe, 2'h0}, "pins");
    chk(8'h00, irq_oe[7:0] | irq_oe[15:8], "irq_oe");
    chk({5'h0, PPMC_ECP}, {5'h0, mode}, "reset mode");
  endtask
  task t_enable();
    bus(1, 0, 11'h0f0, 8'h00);
    chk(8'he0, cfg_rdata, "setup");
    bus(0, 1, 11'h002, 8'h00);
    chk(8'h00, {init_out_n, data_strobe_oe, 6'h0}, "inactive");
    bus(1, 1, 11'h0f8, 8'h10);
    chk(8'h80, {init_out_n, 7'h0}, "init");
  endtask
  task automatic t_static();
    ppmc_mode_t exp [4] = '{PPMC_SPP_COMPAT, PPMC_SPP_EXT, PPMC_EPP17, PPMC_EPP19};
    for (int i = 0; i < 4; i++) begin
      bus(1, 1, 11'h0f0, {i[2:0], 5'h0});
      chk({5'h0, exp[i]}, {5'h0, mode}, "static mode");
      chk({7'h0, i != 2}, {7'h0, full_handshake}, "handshake");
      if (i < 2) begin
        // direction bit set: compatible still drives, extended reads the pins
        bus(0, 1, 11'h002, 8'h24);
        bus(0, 1, 11'h000, 8'h5a);
        bus(0, 0, 11'h000, 8'h00);
        chk(i == 0 ? 8'h5a : 8'ha5, io_rdata, "data read");
        chk({7'h0, i == 0}, {7'h0, pd_oe}, "data drive");
        bus(0, 1, 11'h002, 8'h04);
      end
    end
  endtask
  task t_dyn();
    bus(1, 1, 11'h0f0, 8'hf0);
    bus(0, 1, 11'h002, 8'h04);
    for (int c = 0; c < 4; c++) begin
      bus(0, 1, 11'h402, {c[2:0], 5'h0});
      chk({5'h0, c[2:0]}, {5'h0, mode}, "run-time mode");
    end
    bus(0, 1, 11'h403, 8'h02);
    bus(0, 1, 11'h404, 8'h90);
    bus(0, 0, 11'h404, 8'h00);
    chk(8'h90, io_rdata, "second level");
    bus(0, 1, 11'h402, 8'h80);
    chk({4'h0, PPMC_EPP19, 1'b1}, {4'h0, mode, compat_variant}, "epp19");
    bus(0, 1, 11'h404, 8'h00);
    chk({4'h0, PPMC_EPP17, 1'b0}, {4'h0, mode, full_handshake}, "epp17");
    bus(1, 1, 11'h0f0, 8'hd0);
    chk({5'h0, PPMC_EPP17}, {5'h0, mode}, "setup 110");
    bus(1, 1, 11'h0f0, 8'he0);
    chk({5'h0, PPMC_ECP}, {5'h0, mode}, "setup static");
  endtask
  task t_route();
    bus(1, 1, 11'h0f0, 8'hf0);
    bus(0, 1, 11'h402, 8'h68);
    bus(1, 1, 11'h074, 8'h01);
    chk(8'h01, {5'h0, drq_o}, "drq ch1");
    bus(1, 1, 11'h074, 8'h03);
    chk(8'h04, {5'h0, drq_o}, "drq ch3");
    bus(1, 1, 11'h070, 8'h02);
    chk(8'h00, {7'h0, irq_oe[2]}, "irq 2");
    bus(1, 1, 11'h070, 8'h0d);
    chk(8'h00, {7'h0, irq_oe[13]}, "irq 13");
    bus(1, 1, 11'h070, 8'h05);
    chk(8'h80, {irq_oe[5], irq_o[5], 6'h0}, "irq 5");
  endtask
  task t_fifo();
    bus(0, 1, 11'h402, 8'h40);
    stall = 1'b1;
    k = 0;
    while (io_wr_ready === 1'b1 && k < 40) begin
      bus(0, 1, 11'h400, k[7:0]);
      k++;
    end
    chk(8'h20, k[7:0], "fill");
    stall = 1'b0;
    repeat (1000) if (n_got < 8'h20) @(posedge core_clk);
    chk(8'h20, n_got, "drained");
    chk(8'h1f, got, "last byte");
    chk(8'h05, slen, "strobe");
    bus(0, 1, 11'h402, 8'h60);
    stall = 1'b1;
    k = 0;
    while (io_wr_ready === 1'b1 && k < 40) begin
      bus(0, 1, 11'h400, k[7:0]);
      k++;
    end
    chk(8'h10, k[7:0], "ecp fill");
    stall = 1'b0;
    repeat (1000) if (n_got < 8'h30) @(posedge core_clk);
    chk(8'h30, n_got, "ecp drained");
    chk(8'h0f, got, "ecp last byte");
  endtask
  initial begin
    {srst, io_wr, io_rd, cfg_wr, cfg_rd, stall} = 6'h20;
    {io_addr, io_wdata, cfg_index, cfg_wdata, dack_i} = '0;
    repeat (10) @(posedge core_clk);
    #1;
    t_reset();
    srst = 1'b0;
    t_enable();
    t_static();
    t_dyn();
    t_route();
    t_fifo();
    test_done();
  end
endmodule
